// File: spe_pkg.sv
package spe_pkg;
  // entry key and serial word sizes
  localparam int          KEY_BITS    = 32;
  localparam logic [31:0] ENTRY_KEY   = 32'h4d43_4850;
  localparam int          CMD_BITS    = 6;
  localparam int          DATA_BITS   = 24;
  // serial commands of the session
  localparam logic [5:0]  CMD_LOAD    = 6'h02;
  localparam logic [5:0]  CMD_READ    = 6'h04;
  localparam logic [5:0]  CMD_INC     = 6'h06;
  localparam logic [5:0]  CMD_CFG_WR  = 6'h08;
  // field position of the low-voltage entry bit in the config word
  localparam int          LVE_BIT     = 0;
  localparam int          RSTEN_BIT   = 1;
  localparam logic [13:0] CFG_RESET   = 14'h0003;
  // memory layout: words below CFG_ADDR are program and user ids
  localparam int          ADDR_BITS   = 8;
  localparam logic [7:0]  CFG_ADDR    = 8'hff;
  // link timing: programmer clock divider half period in sys_clk cycles
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          HALF_NS     = 200;
  localparam int          HALF_CYC    = HALF_NS / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC  = 8;
endpackage : spe_pkg

// File: spe_link_if.sv
`timescale 1ns/100ps
// wires between programmer and target
interface spe_link_if;
  logic prog_serial_clock;   // driven by programmer only
  logic data_prg_out;        // programmer data drive value
  logic data_prg_oe_n;       // low while programmer drives
  logic data_tgt_out;        // target data drive value
  logic data_tgt_oe_n;       // low while target drives
  logic ext_reset_pin;       // reset/program-voltage level, low = held
  logic ext_reset_hv;        // high-voltage level on the reset pin
  logic prog_serial_data;    // resolved wire, pulled up when idle
  assign prog_serial_data = !data_prg_oe_n ? data_prg_out :
                            !data_tgt_oe_n ? data_tgt_out : 1'b1;
  modport target (input prog_serial_clock, input prog_serial_data,
                  input ext_reset_pin, input ext_reset_hv,
                  output data_tgt_out, output data_tgt_oe_n);
  modport programmer (output prog_serial_clock, output data_prg_out,
                      output data_prg_oe_n, output ext_reset_pin,
                      output ext_reset_hv, input prog_serial_data);
endinterface : spe_link_if

// File: spe_target.sv
`timescale 1ns/100ps
// How it works
// - data line two-way, clock input only
// - session accepts memory reads/writes and config writes
// - programmer holds clock/data low before HV
// - low-voltage entry only when enable bit set
// - programmer pulls reset low, shifts 32-bit key
// - low-voltage session lasts only while reset stays low
// - enable bit forces reset function on
// - enable bit clears only in HV session
module spe_target #(
  parameter int MEM_WORDS = 256
) (
  input  wire logic  sys_clk,                 // 20 MHz clock
  input  wire logic  rst,                     // async reset, high
  spe_link_if.target link,                    // programming pins
  output logic       prog_mode,               // in program/verify
  output logic       hv_session,              // entered by high voltage
  output logic       low_voltage_entry_enable,// config bit state
  output logic       reset_func_en            // effective reset enable
);
  typedef enum {ST_RUN, ST_KEY, ST_CMD, ST_DATA, ST_READ} spe_tstate_e;

  // pin synchronisers
  logic [1:0] clk_s_r, dat_s_r, rst_s_r, hv_s_r;
  logic       clk_d_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_s_r <= 2'h0;
      dat_s_r <= 2'h0;
      rst_s_r <= 2'h3;
      hv_s_r  <= 2'h0;
      clk_d_r <= 1'b0;
    end else begin
      clk_s_r <= {clk_s_r[0], link.prog_serial_clock};
      dat_s_r <= {dat_s_r[0], link.prog_serial_data};
      rst_s_r <= {rst_s_r[0], link.ext_reset_pin};
      hv_s_r  <= {hv_s_r[0], link.ext_reset_hv};
      clk_d_r <= clk_s_r[1];
    end
  end
  wire logic rise = clk_s_r[1] & ~clk_d_r;
  wire logic fall = ~clk_s_r[1] & clk_d_r;
  wire logic sdat = dat_s_r[1];
  wire logic rpin = rst_s_r[1];
  wire logic hv   = hv_s_r[1];

  logic [13:0]          mem [MEM_WORDS];
  spe_tstate_e          st_r, st_nxt;
  logic [31:0]          sh_r, sh_nxt;
  logic [5:0]           cnt_r, cnt_nxt;
  logic [5:0]           cmd_r, cmd_nxt;
  logic [7:0]           addr_r, addr_nxt;
  logic [13:0]          cfg_r, cfg_nxt;
  logic                 hv_r, hv_nxt;
  logic                 oe_n_r, oe_n_nxt;
  logic                 dout_r, dout_nxt;
  logic                 we;
  logic [13:0]          wdata;

  // serial session sequencer
  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    cmd_nxt  = cmd_r;
    addr_nxt = addr_r;
    cfg_nxt  = cfg_r;
    hv_nxt   = hv_r;
    oe_n_nxt = oe_n_r;
    dout_nxt = dout_r;
    we       = 1'b0;
    wdata    = sh_r[13:0];
    case (st_r)
      ST_RUN: begin
        oe_n_nxt = 1'b1;
        if (hv && !clk_s_r[1] && !sdat) begin
          st_nxt = ST_CMD;
          hv_nxt = 1'b1;
          cnt_nxt = 6'h0;
          addr_nxt = 8'h0;
        end else if (!rpin && cfg_r[spe_pkg::LVE_BIT]) begin
          st_nxt  = ST_KEY;
          cnt_nxt = 6'h0;
          hv_nxt  = 1'b0;
        end
      end
      ST_KEY: begin
        if (fall) begin
          sh_nxt  = {sh_r[30:0], sdat};
          cnt_nxt = cnt_r + 6'h1;
        end
        if (cnt_r == 6'(spe_pkg::KEY_BITS)) begin
          cnt_nxt  = 6'h0;
          addr_nxt = 8'h0;
          st_nxt   = (sh_r == spe_pkg::ENTRY_KEY) ? ST_CMD : ST_RUN;
        end
      end
      ST_CMD: begin
        oe_n_nxt = 1'b1;
        if (fall) begin
          cmd_nxt = {sdat, cmd_r[5:1]};
          cnt_nxt = cnt_r + 6'h1;
        end
        if (cnt_r == 6'(spe_pkg::CMD_BITS)) begin
          cnt_nxt = 6'h0;
          sh_nxt  = {18'h0, mem[addr_r]};
          case (cmd_r)
            spe_pkg::CMD_INC:  addr_nxt = addr_r + 8'h1;
            spe_pkg::CMD_READ: st_nxt = ST_READ;
            spe_pkg::CMD_LOAD, spe_pkg::CMD_CFG_WR: st_nxt = ST_DATA;
            default: st_nxt = ST_CMD;
          endcase
        end
      end
      ST_DATA: begin
        if (fall) begin
          sh_nxt  = {sh_r[30:0], sdat};
          cnt_nxt = cnt_r + 6'h1;
        end
        if (cnt_r == 6'(spe_pkg::DATA_BITS)) begin
          cnt_nxt = 6'h0;
          st_nxt  = ST_CMD;
          if (cmd_r == spe_pkg::CMD_CFG_WR) begin
            cfg_nxt = sh_r[13:0];
            if (!hv_r)
              cfg_nxt[spe_pkg::LVE_BIT] = cfg_r[spe_pkg::LVE_BIT];
          end else begin
            we = 1'b1;
          end
        end
      end
      ST_READ: begin
        oe_n_nxt = 1'b0;
        // bit stands from one rise to the next, so it covers the fall
        dout_nxt = sh_r[13];
        if (rise) begin
          sh_nxt   = {sh_r[30:0], 1'b0};
          cnt_nxt  = cnt_r + 6'h1;
        end
        if (cnt_r == 6'd14 && fall) begin
          cnt_nxt  = 6'h0;
          oe_n_nxt = 1'b1;
          st_nxt   = ST_CMD;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
    // LV session ends when reset pin releases, an HV session only when HV drops
    if (st_r != ST_RUN && st_r != ST_KEY &&
        (hv_r ? !hv : rpin)) begin
      st_nxt   = ST_RUN;
      oe_n_nxt = 1'b1;
    end
    if (st_r == ST_KEY && rpin)
      st_nxt = ST_RUN;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r    <= ST_RUN;
      sh_r    <= 32'h0;
      cnt_r   <= 6'h0;
      cmd_r   <= 6'h0;
      addr_r  <= 8'h0;
      cfg_r   <= spe_pkg::CFG_RESET;
      hv_r    <= 1'b0;
      oe_n_r  <= 1'b1;
      dout_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      cfg_r   <= cfg_nxt;
      hv_r    <= hv_nxt;
      oe_n_r  <= oe_n_nxt;
      dout_r  <= dout_nxt;
    end
  end

  // memory array, no reset
  always_ff @(posedge sys_clk) begin
    if (we)
      mem[addr_r] <= wdata;
  end

  // registered status outputs
  logic pm_r, hs_r, le_r, rf_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm_r <= 1'b0;
      hs_r <= 1'b0;
      le_r <= 1'b1;
      rf_r <= 1'b1;
    end else begin
      pm_r <= (st_r != ST_RUN) && (st_r != ST_KEY);
      hs_r <= hv_r && (st_r != ST_RUN);
      le_r <= cfg_r[spe_pkg::LVE_BIT];
      rf_r <= cfg_r[spe_pkg::RSTEN_BIT] | cfg_r[spe_pkg::LVE_BIT];
    end
  end
  assign prog_mode                = pm_r;
  assign hv_session               = hs_r;
  assign low_voltage_entry_enable = le_r;
  assign reset_func_en            = rf_r;
  assign link.data_tgt_out        = dout_r;
  assign link.data_tgt_oe_n       = oe_n_r;
endmodule : spe_target

// File: spe_programmer.sv
`timescale 1ns/100ps
// programmer end: makes the serial clock and drives entry sequences
module spe_programmer (
  input  wire logic        sys_clk,    // 20 MHz clock
  input  wire logic        rst,        // async reset, high
  spe_link_if.programmer   link,       // programming pins
  input  wire logic        start_lv,   // pulse: low-voltage entry
  input  wire logic        start_hv,   // pulse: high-voltage entry
  input  wire logic        end_sess,   // pulse: leave session
  input  wire logic        xfer_go,    // pulse: shift word out
  input  wire logic [5:0]  xfer_len,   // bits to shift, lsb first
  input  wire logic [31:0] xfer_word,  // bits to shift
  input  wire logic        rd_go,      // pulse: read 14 bits
  output logic             busy,       // sequence running
  output logic [13:0]      rd_data     // last read word
);
  typedef enum {PS_IDLE, PS_HVSET, PS_KEY, PS_SHIFT, PS_READ}
    spe_pstate_e;

  logic [1:0]  din_s_r;
  spe_pstate_e st_r, st_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [3:0]  div_r, div_nxt;
  logic        sck_r, sck_nxt, do_r, do_nxt, oe_n_r, oe_n_nxt;
  logic        rst_r, rst_nxt, hv_r, hv_nxt, bsy_r, bsy_nxt;
  logic [13:0] rd_r, rd_nxt;
  logic        tick, seq_done;

  // entry sequences and clock divider
  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    sck_nxt  = sck_r;
    do_nxt   = do_r;
    oe_n_nxt = oe_n_r;
    rst_nxt  = rst_r;
    hv_nxt   = hv_r;
    rd_nxt   = rd_r;
    tick     = (div_r == 4'(spe_pkg::HALF_CYC - 1));
    div_nxt  = tick ? 4'h0 : div_r + 4'h1;
    bsy_nxt  = (st_r != PS_IDLE);
    // all bits out: key counts up to its length, a word down to zero
    seq_done = (st_r == PS_KEY) ? (cnt_r == 6'(spe_pkg::KEY_BITS))
                                : (cnt_r == 6'h0);
    case (st_r)
      PS_IDLE: begin
        sck_nxt = 1'b0;
        if (end_sess) begin
          rst_nxt  = 1'b1;
          hv_nxt   = 1'b0;
          oe_n_nxt = 1'b1;
        end else if (start_hv) begin
          do_nxt   = 1'b0;
          oe_n_nxt = 1'b0;
          cnt_nxt  = 6'h0;
          st_nxt   = PS_HVSET;
        end else if (start_lv) begin
          rst_nxt  = 1'b0;
          oe_n_nxt = 1'b0;
          sh_nxt   = spe_pkg::ENTRY_KEY;
          cnt_nxt  = 6'h0;
          st_nxt   = PS_KEY;
        end else if (xfer_go) begin
          sh_nxt   = xfer_word;
          cnt_nxt  = xfer_len;
          oe_n_nxt = 1'b0;
          st_nxt   = PS_SHIFT;
        end else if (rd_go) begin
          oe_n_nxt = 1'b1;
          cnt_nxt  = 6'd14;
          st_nxt   = PS_READ;
        end
      end
      PS_HVSET: begin
        if (tick) begin
          cnt_nxt = cnt_r + 6'h1;
          if (cnt_r == 6'(spe_pkg::SETTLE_CYC)) begin
            hv_nxt = 1'b1;
            st_nxt = PS_IDLE;
          end
        end
      end
      PS_KEY, PS_SHIFT: begin
        if (tick) begin
          if (seq_done) begin
            // let go of data half a period after the last fall, so the
            // target has sampled it before it may answer
            oe_n_nxt = 1'b1;
            st_nxt   = PS_IDLE; // reset keeps its level afterwards: low after the key, high after an HV shift
          end else begin
            sck_nxt = ~sck_r;
            if (!sck_r) begin
              do_nxt = (st_r == PS_KEY) ? sh_r[31] : sh_r[0];
            end else begin
              sh_nxt  = (st_r == PS_KEY) ? {sh_r[30:0], 1'b0}
                                         : {1'b0, sh_r[31:1]};
              cnt_nxt = (st_r == PS_KEY) ? cnt_r + 6'h1 : cnt_r - 6'h1;
            end
          end
        end
      end
      PS_READ: begin
        if (tick) begin
          sck_nxt = ~sck_r;
          if (sck_r) begin
            rd_nxt  = {rd_r[12:0], din_s_r[1]}; // sampled at the fall
            cnt_nxt = cnt_r - 6'h1;
            if (cnt_r == 6'h1)
              st_nxt = PS_IDLE;
          end
        end
      end
      default: st_nxt = PS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r    <= PS_IDLE;
      sh_r    <= 32'h0;
      cnt_r   <= 6'h0;
      div_r   <= 4'h0;
      sck_r   <= 1'b0;
      do_r    <= 1'b0;
      oe_n_r  <= 1'b1;
      rst_r   <= 1'b1;
      hv_r    <= 1'b0;
      bsy_r   <= 1'b0;
      rd_r    <= 14'h0;
      din_s_r <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      div_r   <= div_nxt;
      sck_r   <= sck_nxt;
      do_r    <= do_nxt;
      oe_n_r  <= oe_n_nxt;
      rst_r   <= rst_nxt;
      hv_r    <= hv_nxt;
      bsy_r   <= bsy_nxt;
      rd_r    <= rd_nxt;
      din_s_r <= {din_s_r[0], link.prog_serial_data};
    end
  end
  assign link.prog_serial_clock = sck_r;
  assign link.data_prg_out      = do_r;
  assign link.data_prg_oe_n     = oe_n_r;
  assign link.ext_reset_pin     = rst_r;
  assign link.ext_reset_hv      = hv_r;
  assign busy                   = bsy_r;
  assign rd_data                = rd_r;
endmodule : spe_programmer

// File: spe_link_monitor.sv
`timescale 1ns/100ps
// watches the programming wires between the two ends
module spe_link_monitor (
  input logic sys_clk,           // system clock
  input logic rst,               // async reset, high
  input logic prog_serial_clock, // programmer clock
  input logic data_prg_out,      // programmer data value
  input logic data_prg_oe_n,     // programmer drive, low
  input logic data_tgt_oe_n,     // target drive, low
  input logic ext_reset_pin,     // reset pin level
  input logic ext_reset_hv,      // high-voltage level
  input logic prog_serial_data   // resolved data wire
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // wire rules
  property p_one_driver;
    !(!data_prg_oe_n && !data_tgt_oe_n);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data wire");
  property p_clk_still;
    ext_reset_pin && !ext_reset_hv |-> !prog_serial_clock;
  endproperty
  a_clk_still: assert property (p_clk_still)
    else $error("link clock moves outside a session");
  property p_hv_entry;
    $rose(ext_reset_hv) |-> !prog_serial_clock && !prog_serial_data;
  endproperty
  a_hv_entry: assert property (p_hv_entry)
    else $error("high voltage raised with clock or data high");
  property p_clk_high;
    $rose(prog_serial_clock) |-> prog_serial_clock[*4] ##1 !prog_serial_clock;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high phase not four cycles");
  property p_clk_low;
    $fell(prog_serial_clock) |-> !prog_serial_clock[*4];
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("link clock low phase too short");
  property p_data_hold;
    prog_serial_clock && $past(prog_serial_clock) && !data_prg_oe_n
      && !$past(data_prg_oe_n) |-> $stable(data_prg_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("programmer data moved while clock high");
  property p_key_quiet;
    $fell(ext_reset_pin) |-> data_tgt_oe_n[*8];
  endproperty
  a_key_quiet: assert property (p_key_quiet)
    else $error("target drove data during key");
  property p_tgt_session;
    !data_tgt_oe_n |-> !ext_reset_pin || ext_reset_hv;
  endproperty
  a_tgt_session: assert property (p_tgt_session)
    else $error("target drove data outside a session");
endmodule : spe_link_monitor

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic start_lv = 0, start_hv = 0, end_sess = 0, xfer_go = 0, rd_go = 0;
  logic [5:0] xfer_len = 6'h00;
  logic [31:0] xfer_word = 32'h0;
  logic busy, pm, hvs, lve, rfe, pm2;
  logic [13:0] rd_data;
  int miscompares = 0;
  int comparisons = 0;
  spe_link_if link();
  spe_link_if link2();
  // both ends face each other; second target is driven by the bench
  spe_programmer spe_programmer_inst (.sys_clk(sys_clk), .rst(rst),
    .link(link), .start_lv(start_lv), .start_hv(start_hv),
    .end_sess(end_sess), .xfer_go(xfer_go), .xfer_len(xfer_len),
    .xfer_word(xfer_word), .rd_go(rd_go), .busy(busy), .rd_data(rd_data));
  spe_target spe_target_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
    .prog_mode(pm), .hv_session(hvs), .low_voltage_entry_enable(lve),
    .reset_func_en(rfe));
  spe_target spe_target_inst2 (.sys_clk(sys_clk), .rst(rst), .link(link2),
    .prog_mode(pm2), .hv_session(), .low_voltage_entry_enable(),
    .reset_func_en());
  spe_link_monitor spe_link_monitor_inst (.sys_clk(sys_clk), .rst(rst),
    .prog_serial_clock(link.prog_serial_clock),
    .data_prg_out(link.data_prg_out), .data_prg_oe_n(link.data_prg_oe_n),
    .data_tgt_oe_n(link.data_tgt_oe_n), .ext_reset_pin(link.ext_reset_pin),
    .ext_reset_hv(link.ext_reset_hv),
    .prog_serial_data(link.prog_serial_data));
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  task check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : check
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // one-cycle request pulse, then bounded wait for idle and settling
  task do_op(input logic [4:0] sel);
    int n;
    {start_lv, start_hv, end_sess, xfer_go, rd_go} = sel;
    @(negedge sys_clk);
    {start_lv, start_hv, end_sess, xfer_go, rd_go} = 5'h00;
    @(negedge sys_clk); // busy shows one cycle after the pulse is taken
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge sys_clk);
    check("busy_done", busy, 1'b0);
    repeat (12) @(negedge sys_clk);
  endtask : do_op
  task send(input logic [5:0] len, input logic [31:0] w);
    xfer_len = len;
    xfer_word = w;
    do_op(5'h02);
  endtask : send
  // bench plays the programmer on the second link, key msb first
  task key2(input logic [31:0] k);
    link2.ext_reset_pin = 1'b0;
    link2.data_prg_oe_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (4) @(negedge sys_clk);
      link2.prog_serial_clock = 1'b1;
      link2.data_prg_out = k[i]; // data moves only with the rising clock
      repeat (4) @(negedge sys_clk);
      link2.prog_serial_clock = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    link2.data_prg_oe_n = 1'b1;
    link2.data_prg_out = ~k[0];
    repeat (12) @(negedge sys_clk);
  endtask : key2
  task t_reset;
    check("prog_mode", pm, 1'b0);
    check("lve", lve, 1'b1);
    check("rst_en", rfe, 1'b1);
    check("rst_pin", link.ext_reset_pin, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task t_lv;
    do_op(5'h10);
    check("lv_mode", pm, 1'b1);
    check("lv_hv", hvs, 1'b0);
    send(6'h06, {26'h0, spe_pkg::CMD_CFG_WR});
    send(6'h18, 32'h0);
    check("lv_clr", lve, 1'b1);
    check("lv_rfe", rfe, 1'b1);
    do_op(5'h04);
    check("lv_end", pm, 1'b0);
    $display("low-voltage test done");
  endtask : t_lv
  task t_hv;
    do_op(5'h08);
    check("hv_mode", pm, 1'b1);
    check("hv_flag", hvs, 1'b1);
    send(6'h06, {26'h0, spe_pkg::CMD_LOAD});
    send(6'h18, 32'h00ff_ffff);
    send(6'h06, {26'h0, spe_pkg::CMD_READ});
    do_op(5'h01);
    check("rd_data", rd_data, 14'h3fff);
    // step on, overwrite the next word, re-enter: word zero must survive
    send(6'h06, {26'h0, spe_pkg::CMD_INC});
    send(6'h06, {26'h0, spe_pkg::CMD_LOAD});
    send(6'h18, 32'h0);
    do_op(5'h04);
    do_op(5'h08);
    send(6'h06, {26'h0, spe_pkg::CMD_READ});
    do_op(5'h01);
    check("inc_rd", rd_data, 14'h3fff);
    send(6'h06, {26'h0, spe_pkg::CMD_CFG_WR});
    send(6'h18, 32'h0);
    check("hv_clr", lve, 1'b0);
    check("hv_rfe", rfe, 1'b0);
    do_op(5'h04);
    check("hv_end", pm, 1'b0);
    $display("high-voltage test done");
  endtask : t_hv
  task t_refused;
    do_op(5'h10);
    check("lv_refused", pm, 1'b0);
    do_op(5'h04);
    $display("refused entry test done");
  endtask : t_refused
  task t_key;
    key2(spe_pkg::ENTRY_KEY ^ 32'h1);
    check("bad_key", pm2, 1'b0);
    link2.ext_reset_pin = 1'b1;
    repeat (12) @(negedge sys_clk);
    key2(spe_pkg::ENTRY_KEY);
    check("good_key", pm2, 1'b1);
    link2.ext_reset_pin = 1'b1;
    repeat (12) @(negedge sys_clk);
    check("key_end", pm2, 1'b0);
    $display("key test done");
  endtask : t_key
  // main sequence
  initial begin
    link2.prog_serial_clock = 1'b0;
    link2.data_prg_out = 1'b0;
    link2.data_prg_oe_n = 1'b1;
    link2.ext_reset_pin = 1'b1;
    link2.ext_reset_hv = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_reset();
    t_lv();
    t_hv();
    t_refused();
    t_key();
    final_report();
  end
  // watchdog
  initial begin
    #2000000;
    miscompares++;
    final_report();
  end
endmodule : tb
